// [rtl/rotate_subtract_skip_alu.sv]
// Accumulator datapath slice: rotates, subtracts, skip tests, bit set.
// Assumes a sequencer on the same clock that drives requests and data.
`timescale 1ns/100ps
`include "rss_cfg.svh"

// What this block does
// - Rotate memory left into work_reg, bit 7 wraps, flags untouched.
// - Rotate memory left through borrow_bit, result back to memory.
// - Same rotate through borrow_bit, result to work_reg only.
// - Rotate memory right in place, bit 0 wraps, flags untouched.
// - Rotate memory right into work_reg, memory and flags untouched.
// - Rotate right through borrow_bit, to memory or work_reg.
// - Subtract operand and inverted borrow_bit from work_reg.
// - Subtraction clears borrow_bit on negative, sets it otherwise.
// - Subtract operand from work_reg ignoring borrow_bit.
// - Every subtraction updates all six arithmetic flags.
// - Decrement memory in place; zero result skips next instruction.
// - Decrement into work_reg, memory kept; zero skips next.
// - Increment to memory or work_reg; zero skips next.
// - Every skip-type operation takes two cycles with a dummy.
// - Fill addressed byte with all ones, flags untouched.
// - Force selected bit to one, other bits and flags kept.
// - Skip next when the selected bit is nonzero.
// - Write byte back unchanged; skip next when it is nonzero.
// - Exchange the two nibbles of the byte in place.
module rotate_subtract_skip_alu (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire rss_pkg::req_t i_req,
    output logic o_ready,
    output logic o_done,
    output logic o_skip,
    output logic o_mem_we,
    output logic [`RSS_DATA_W-1:0] o_mem_wdata,
    output logic [`RSS_DATA_W-1:0] o_work_reg,
    output rss_pkg::flags_t o_flags
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    rss_pkg::core_t st_reg;
    rss_pkg::core_t st_next;
    logic taken;
    logic [`RSS_DATA_W-1:0] mem;
    logic [`RSS_DATA_W-1:0] opnd;
    logic [`RSS_DATA_W-1:0] res;
    logic [`RSS_DATA_W:0] diff;
    logic [`RSS_NIB_W:0] nib;
    logic cin;
    logic borrow_op;

    assign taken = i_req.valid && st_reg.ready;
    assign mem = i_req.mem_data;
    assign opnd = i_req.src_imm ? i_req.imm_data : mem;
    assign borrow_op = (i_req.op == rss_pkg::OP_MINUS_WITH_BORROW);

    // ------------------------------------------------------------
    // Subtractor
    // ------------------------------------------------------------
    // Borrow folded in as carry
    assign cin = borrow_op ? st_reg.flags.borrow_bit : 1'b1;
    assign diff = {1'b0, st_reg.work} + {1'b0, ~opnd}
        + {{`RSS_DATA_W{1'b0}}, cin};
    assign nib = {1'b0, st_reg.work[`RSS_NIB_W-1:0]}
        + {1'b0, ~opnd[`RSS_NIB_W-1:0]} + {{`RSS_NIB_W{1'b0}}, cin};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.state = rss_pkg::ST_IDLE;
        st_next.ready = 1'b1;
        st_next.done = 1'b0;
        st_next.skip = 1'b0;
        st_next.mem_we = 1'b0;
        res = `RSS_ZERO;
        if (taken) begin
            st_next.done = 1'b1;
            case (i_req.op)
                rss_pkg::OP_LOAD_WORK: begin
                    st_next.work = opnd;
                end
                rss_pkg::OP_ROTL_TO_WORK: begin
                    st_next.work = {mem[`RSS_MSB-1:`RSS_LSB], mem[`RSS_MSB]};
                end
                // Left rotate through borrow to memory
                rss_pkg::OP_ROTL_THRU_BORROW: begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = {mem[`RSS_MSB-1:`RSS_LSB],
                        st_reg.flags.borrow_bit};
                    st_next.flags.borrow_bit = mem[`RSS_MSB];
                end
                // Left rotate through borrow to work_reg
                rss_pkg::OP_ROTL_THRU_BORROW_TO_WORK: begin
                    st_next.work = {mem[`RSS_MSB-1:`RSS_LSB],
                        st_reg.flags.borrow_bit};
                    st_next.flags.borrow_bit = mem[`RSS_MSB];
                end
                rss_pkg::OP_ROTR_MEM: begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = {mem[`RSS_LSB], mem[`RSS_MSB:`RSS_B1]};
                end
                rss_pkg::OP_ROTR_TO_WORK: begin
                    st_next.work = {mem[`RSS_LSB], mem[`RSS_MSB:`RSS_B1]};
                end
                // Right rotate through borrow to memory
                rss_pkg::OP_ROTR_THRU_BORROW: begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = {st_reg.flags.borrow_bit,
                        mem[`RSS_MSB:`RSS_B1]};
                    st_next.flags.borrow_bit = mem[`RSS_LSB];
                end
                // Right rotate through borrow to work_reg
                rss_pkg::OP_ROTR_THRU_BORROW_TO_WORK: begin
                    st_next.work = {st_reg.flags.borrow_bit,
                        mem[`RSS_MSB:`RSS_B1]};
                    st_next.flags.borrow_bit = mem[`RSS_LSB];
                end
                // Both subtract forms share the datapath
                rss_pkg::OP_MINUS_WITH_BORROW,
                rss_pkg::OP_MINUS_OP: begin
                    res = diff[`RSS_MSB:`RSS_LSB];
                    if (i_req.dest_mem) begin
                        st_next.mem_we = 1'b1;
                        st_next.mem_wdata = res;
                    end else begin
                        st_next.work = res;
                    end
                    // Borrow flag is the carry out
                    st_next.flags.borrow_bit = diff[`RSS_DATA_W];
                    st_next.flags.signed_wrap_flag =
                        (st_reg.work[`RSS_MSB] != opnd[`RSS_MSB])
                        && (res[`RSS_MSB] != st_reg.work[`RSS_MSB]);
                    st_next.flags.nil_result_flag = (res == `RSS_ZERO);
                    st_next.flags.nibble_borrow_bit = nib[`RSS_NIB_W];
                    st_next.flags.signed_borrow_bit =
                        ~(st_next.flags.signed_wrap_flag ^ res[`RSS_MSB]);
                    st_next.flags.chain_nil_flag = (res == `RSS_ZERO)
                        && (!borrow_op || st_reg.flags.chain_nil_flag);
                end
                rss_pkg::OP_DEC_SKIP_NIL: begin
                    res = mem - `RSS_ONE;
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = res;
                    st_next.skip = (res == `RSS_ZERO);
                end
                rss_pkg::OP_DEC_SKIP_NIL_TO_WORK: begin
                    res = mem - `RSS_ONE;
                    st_next.work = res;
                    st_next.skip = (res == `RSS_ZERO);
                end
                rss_pkg::OP_INC_SKIP_NIL: begin
                    res = mem + `RSS_ONE;
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = res;
                    st_next.skip = (res == `RSS_ZERO);
                end
                rss_pkg::OP_INC_SKIP_NIL_TO_WORK: begin
                    res = mem + `RSS_ONE;
                    st_next.work = res;
                    st_next.skip = (res == `RSS_ZERO);
                end
                rss_pkg::OP_FILL_ONES: begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = `RSS_ALL_ONES;
                end
                rss_pkg::OP_BIT_SET: begin
                    res = mem;
                    res[i_req.bit_idx] = 1'b1;
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = res;
                end
                rss_pkg::OP_SKIP_NONNIL_BIT: begin
                    st_next.skip = mem[i_req.bit_idx];
                end
                // Write back and skip on nonzero byte
                rss_pkg::OP_SKIP_NONNIL_BYTE: begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = mem;
                    st_next.skip = (mem != `RSS_ZERO);
                end
                rss_pkg::OP_NIBBLE_EXCHANGE: begin
                    st_next.mem_we = 1'b1;
                    st_next.mem_wdata = {mem[`RSS_NIB_W-1:`RSS_LSB],
                        mem[`RSS_MSB:`RSS_NIB_W]};
                end
                default: begin
                    st_next.done = 1'b0;
                end
            endcase
            // Skip-type operations hold a dummy cycle
            case (i_req.op)
                rss_pkg::OP_DEC_SKIP_NIL,
                rss_pkg::OP_DEC_SKIP_NIL_TO_WORK,
                rss_pkg::OP_INC_SKIP_NIL,
                rss_pkg::OP_INC_SKIP_NIL_TO_WORK,
                rss_pkg::OP_SKIP_NONNIL_BIT,
                rss_pkg::OP_SKIP_NONNIL_BYTE: begin
                    st_next.state = rss_pkg::ST_DUMMY;
                    st_next.ready = 1'b0;
                end
                default: begin
                    st_next.state = rss_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_reg.state <= rss_pkg::ST_IDLE;
            st_reg.ready <= 1'b1;
            st_reg.done <= 1'b0;
            st_reg.skip <= 1'b0;
            st_reg.mem_we <= 1'b0;
            st_reg.mem_wdata <= `RSS_ZERO;
            st_reg.work <= `RSS_WORK_RST;
            st_reg.flags <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_ready = st_reg.ready;
    assign o_done = st_reg.done;
    assign o_skip = st_reg.skip;
    assign o_mem_we = st_reg.mem_we;
    assign o_mem_wdata = st_reg.mem_wdata;
    assign o_work_reg = st_reg.work;
    assign o_flags = st_reg.flags;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    rotl_work_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_ROTL_TO_WORK |=>
        o_work_reg == {$past(mem[`RSS_MSB-1:`RSS_LSB]), $past(mem[`RSS_MSB])}
        && !o_mem_we && o_flags == $past(o_flags))
        else $error("left rotate to work wrong");

    rotl_borrow_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_ROTL_THRU_BORROW |=>
        o_mem_we && o_mem_wdata[`RSS_LSB] == $past(o_flags.borrow_bit)
        && o_flags.borrow_bit == $past(mem[`RSS_MSB]))
        else $error("left rotate through borrow wrong");

    rotl_borrow_work_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_ROTL_THRU_BORROW_TO_WORK |=>
        !o_mem_we && o_work_reg[`RSS_MSB:1] == $past(mem[`RSS_MSB-1:0])
        && o_flags.borrow_bit == $past(mem[`RSS_MSB]))
        else $error("left rotate through borrow to work wrong");

    rotr_mem_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_ROTR_MEM |=>
        o_mem_we && o_mem_wdata == {$past(mem[`RSS_LSB]),
        $past(mem[`RSS_MSB:1])} && $stable(o_flags))
        else $error("right rotate in place wrong");

    rotr_work_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_ROTR_TO_WORK |=>
        o_work_reg == {$past(mem[`RSS_LSB]), $past(mem[`RSS_MSB:1])}
        && !o_mem_we && $stable(o_flags))
        else $error("right rotate to work wrong");

    rotr_borrow_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_ROTR_THRU_BORROW_TO_WORK |=>
        o_work_reg[`RSS_MSB] == $past(o_flags.borrow_bit)
        && o_flags.borrow_bit == $past(mem[`RSS_LSB]))
        else $error("right rotate through borrow wrong");

    sub_borrow_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_MINUS_OP && !i_req.dest_mem |=>
        o_flags.borrow_bit == ($past(o_work_reg) >= $past(opnd))
        && o_work_reg == $past(st_reg.work - opnd))
        else $error("subtract borrow or result wrong");

    sub_nil_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && borrow_op && i_req.dest_mem |=>
        o_mem_we && o_flags.nil_result_flag == (o_mem_wdata == `RSS_ZERO))
        else $error("subtract zero flag wrong");

    dec_skip_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_DEC_SKIP_NIL |=>
        o_mem_we && o_mem_wdata == $past(mem - 8'h01)
        && o_skip == ($past(mem) == 8'h01))
        else $error("decrement skip wrong");

    skip_dummy_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && st_next.state == rss_pkg::ST_DUMMY |=>
        !o_ready && o_done ##1 o_ready && !o_done)
        else $error("skip dummy cycle wrong");

    fill_ones_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_FILL_ONES |=>
        o_mem_we && o_mem_wdata == `RSS_ALL_ONES && $stable(o_flags))
        else $error("fill ones wrong");

    skip_bit_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_SKIP_NONNIL_BIT |=>
        o_skip == $past(mem[i_req.bit_idx]) && !o_mem_we)
        else $error("bit skip test wrong");

    bit_set_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_BIT_SET |=>
        o_mem_wdata == ($past(mem)
        | (8'h01 << $past(i_req.bit_idx))))
        else $error("bit set wrong");

    swap_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        taken && i_req.op == rss_pkg::OP_NIBBLE_EXCHANGE |=>
        o_mem_wdata == {$past(mem[`RSS_NIB_W-1:0]),
        $past(mem[`RSS_MSB:`RSS_NIB_W])} && $stable(o_work_reg))
        else $error("nibble exchange wrong");

endmodule : rotate_subtract_skip_alu

// [include/rss_cfg.svh]
// Constants for the rotate, subtract and skip datapath slice.
// Assumes nothing beyond being included by the package and the RTL.
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ----------------------------------------------------------------
// Data layout
// ----------------------------------------------------------------
`define RSS_DATA_W 8
`define RSS_MSB 7
`define RSS_LSB 0
`define RSS_B1 1
`define RSS_NIB_W 4
`define RSS_IDX_W 3
`define RSS_OP_W 5

// ----------------------------------------------------------------
// Fixed values and reset values
// ----------------------------------------------------------------
`define RSS_ALL_ONES 8'hFF
`define RSS_ZERO 8'h00
`define RSS_ONE 8'h01
`define RSS_WORK_RST 8'h00
`define RSS_BORROW_RST 1'b0

`endif

// [include/rss_pkg.sv]
// Types shared by the datapath slice and its sequencer.
// Assumes rss_cfg.svh is on the include path.
`include "rss_cfg.svh"

package rss_pkg;

    // ------------------------------------------------------------
    // Operation codes
    // ------------------------------------------------------------
    typedef enum logic [`RSS_OP_W-1:0] {
        OP_NONE = 5'h00,
        OP_LOAD_WORK = 5'h01,
        OP_ROTL_TO_WORK = 5'h02,
        OP_ROTL_THRU_BORROW = 5'h03,
        OP_ROTL_THRU_BORROW_TO_WORK = 5'h04,
        OP_ROTR_MEM = 5'h05,
        OP_ROTR_TO_WORK = 5'h06,
        OP_ROTR_THRU_BORROW = 5'h07,
        OP_ROTR_THRU_BORROW_TO_WORK = 5'h08,
        OP_MINUS_WITH_BORROW = 5'h09,
        OP_MINUS_OP = 5'h0A,
        OP_DEC_SKIP_NIL = 5'h0B,
        OP_DEC_SKIP_NIL_TO_WORK = 5'h0C,
        OP_INC_SKIP_NIL = 5'h0D,
        OP_INC_SKIP_NIL_TO_WORK = 5'h0E,
        OP_FILL_ONES = 5'h0F,
        OP_BIT_SET = 5'h10,
        OP_SKIP_NONNIL_BIT = 5'h11,
        OP_SKIP_NONNIL_BYTE = 5'h12,
        OP_NIBBLE_EXCHANGE = 5'h13
    } op_t;

    // ------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DUMMY = 2'b10
    } seq_state_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed_wrap_flag;
        logic nil_result_flag;
        logic nibble_borrow_bit;
        logic borrow_bit;
        logic signed_borrow_bit;
        logic chain_nil_flag;
    } flags_t;

    typedef struct packed {
        logic valid;
        op_t op;
        logic src_imm;
        logic dest_mem;
        logic [`RSS_IDX_W-1:0] bit_idx;
        logic [`RSS_DATA_W-1:0] mem_data;
        logic [`RSS_DATA_W-1:0] imm_data;
    } req_t;

    typedef struct packed {
        seq_state_t state;
        logic ready;
        logic done;
        logic skip;
        logic mem_we;
        logic [`RSS_DATA_W-1:0] mem_wdata;
        logic [`RSS_DATA_W-1:0] work;
        flags_t flags;
    } core_t;

endpackage : rss_pkg

// [bench/rss_mem_model.sv]
// Data memory byte standing in for the sequencer's memory port.
// Assumes one addressed byte on the datapath's core clock.
`timescale 1ns/100ps
module rss_mem_model (
    input wire logic i_clk,
    input wire logic i_load,
    input wire logic [7:0] i_load_val,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    input wire logic i_skip,
    output logic [7:0] o_rdata,
    output logic [7:0] o_skips
);
    logic [7:0] mem_reg = 8'h00;
    logic [7:0] skips_reg = 8'h00;

    always @(posedge i_clk) begin
        if (i_we) begin
            mem_reg <= i_wdata;
        end
        if (i_load) begin
            mem_reg <= i_load_val;
        end
        if (i_skip) begin
            skips_reg <= skips_reg + 8'h01;
        end
    end

    assign o_rdata = i_load ? i_load_val : mem_reg;
    assign o_skips = skips_reg;
endmodule : rss_mem_model

// [bench/rotate_subtract_skip_alu_tb.sv]
// Self-checking bench for the rotate, subtract and skip datapath.
// Assumes rss_pkg and rss_mem_model are compiled before it.
`timescale 1ns/100ps
module rotate_subtract_skip_alu_tb;
    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    logic i_clk;
    logic i_rst_n;
    logic req_valid;
    rss_pkg::op_t req_op;
    logic req_imm_sel;
    logic req_to_mem;
    logic [2:0] req_idx;
    logic [7:0] req_imm;
    logic load;
    logic [7:0] load_val;
    logic [7:0] mem_rdata;
    logic [7:0] skips;
    rss_pkg::req_t req;
    logic ready;
    logic done;
    logic skip;
    logic mem_we;
    logic [7:0] wdata;
    logic [7:0] work;
    rss_pkg::flags_t flags;
    rss_pkg::flags_t exp_fl;
    int miscompares;
    int tests_run;
    int exp_skips;

    assign req = '{req_valid, req_op, req_imm_sel, req_to_mem, req_idx,
                   mem_rdata, req_imm};

    rotate_subtract_skip_alu u_rotate_subtract_skip_alu (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_req(req),
        .o_ready(ready),
        .o_done(done),
        .o_skip(skip),
        .o_mem_we(mem_we),
        .o_mem_wdata(wdata),
        .o_work_reg(work),
        .o_flags(flags)
    );

    rss_mem_model u_rss_mem_model (
        .i_clk(i_clk),
        .i_load(load),
        .i_load_val(load_val),
        .i_we(mem_we),
        .i_wdata(wdata),
        .i_skip(skip),
        .o_rdata(mem_rdata),
        .o_skips(skips)
    );

    initial begin
        i_clk = 1'h0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        if (miscompares == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task automatic drive(input rss_pkg::op_t op, input logic [7:0] m,
                         input logic is_imm, input logic to_mem,
                         input logic [2:0] idx, input logic [7:0] imm);
        req_valid <= 1'h1;
        req_op <= op;
        req_imm_sel <= is_imm;
        req_to_mem <= to_mem;
        req_idx <= idx;
        req_imm <= imm;
        load <= 1'h1;
        load_val <= m;
    endtask : drive

    task automatic issue(input rss_pkg::op_t op, input logic [7:0] m,
                         input logic is_imm, input logic to_mem,
                         input logic [2:0] idx, input logic [7:0] imm);
        @(posedge i_clk);
        drive(op, m, is_imm, to_mem, idx, imm);
        @(posedge i_clk);
        req_valid <= 1'h0;
        load <= 1'h0;
        #1;
    endtask : issue

    function automatic logic [8:0] rot(input rss_pkg::op_t op,
                                       input logic [7:0] m, input logic c);
        case (op)
            rss_pkg::OP_ROTL_TO_WORK: rot = {c, m[6:0], m[7]};
            rss_pkg::OP_ROTR_MEM: rot = {c, m[0], m[7:1]};
            rss_pkg::OP_ROTR_TO_WORK: rot = {c, m[0], m[7:1]};
            rss_pkg::OP_ROTR_THRU_BORROW: rot = {m[0], c, m[7:1]};
            rss_pkg::OP_ROTR_THRU_BORROW_TO_WORK: rot = {m[0], c, m[7:1]};
            default: rot = {m[7], m[6:0], c};
        endcase
    endfunction : rot

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_rotates;
        rss_pkg::op_t op;
        logic [7:0] m;
        logic [8:0] r;
        for (int k = 2; k <= 8; k++) begin
            op = rss_pkg::op_t'(k);
            m = 8'h81 ^ (8'(k) << 3);
            r = rot(op, m, exp_fl.borrow_bit);
            issue(op, m, 1'h0, 1'h0, 3'h0, 8'h00);
            exp_fl.borrow_bit = r[8];
            check(k[0] ? wdata : work, r[7:0]);
            check(8'({done, mem_we}), {6'h00, 1'h1, k[0]});
            check(8'(flags), 8'(exp_fl));
        end
    endtask : t_rotates

    task automatic t_subtract;
        issue(rss_pkg::OP_LOAD_WORK, 8'h00, 1'h1, 1'h0, 3'h0, 8'h10);
        issue(rss_pkg::OP_MINUS_OP, 8'h20, 1'h0, 1'h0, 3'h0, 8'h00);
        check(work, 8'hF0);
        check(8'(flags), 8'h08);
        issue(rss_pkg::OP_LOAD_WORK, 8'h00, 1'h1, 1'h0, 3'h0, 8'h80);
        issue(rss_pkg::OP_MINUS_WITH_BORROW, 8'h55, 1'h1, 1'h0, 3'h0, 8'h01);
        check(work, 8'h7E);
        check(8'(flags), 8'h24);
        issue(rss_pkg::OP_MINUS_OP, 8'h7E, 1'h0, 1'h1, 3'h0, 8'h00);
        check(8'({mem_we, wdata == 8'h00, work == 8'h7E}), 8'h07);
        check(8'(flags), 8'h1F);
        issue(rss_pkg::OP_MINUS_WITH_BORROW, 8'h7E, 1'h0, 1'h1, 3'h0, 8'h00);
        check(8'({mem_we, wdata == 8'h00}), 8'h03);
        check(8'(flags), 8'h1F);
        issue(rss_pkg::OP_MINUS_WITH_BORROW, 8'h7F, 1'h0, 1'h0, 3'h0, 8'h00);
        check(work, 8'hFF);
        check(8'(flags), 8'h00);
        exp_fl = 6'h00;
    endtask : t_subtract

    task automatic skip_case(input logic [4:0] op, input logic [7:0] m,
                             input logic [2:0] idx, input logic sk,
                             input logic [1:0] mode, input logic [7:0] v);
        issue(rss_pkg::op_t'(op), m, 1'h0, 1'h0, idx, 8'h00);
        exp_skips = exp_skips + int'(sk);
        check(8'({done, ready}), 8'h02);
        check(8'(skip), 8'(sk));
        if (mode == 2'h1) begin
            check(8'(mem_we), 8'h01);
            check(wdata, v);
        end else if (mode == 2'h2) begin
            check(8'(mem_we), 8'h00);
            check(work, v);
        end
        check(8'(flags), 8'(exp_fl));
    endtask : skip_case

    task automatic t_skips;
        // Codes: 0B dec, 0C dec to work, 0D inc, 0E inc to work, 11/12 test
        skip_case(5'h0B, 8'h01, 3'h0, 1'h1, 2'h1, 8'h00);
        skip_case(5'h0B, 8'h00, 3'h0, 1'h0, 2'h1, 8'hFF);
        skip_case(5'h0C, 8'h01, 3'h0, 1'h1, 2'h2, 8'h00);
        skip_case(5'h0C, 8'h00, 3'h0, 1'h0, 2'h2, 8'hFF);
        skip_case(5'h0D, 8'hFF, 3'h0, 1'h1, 2'h1, 8'h00);
        skip_case(5'h0D, 8'h7F, 3'h0, 1'h0, 2'h1, 8'h80);
        skip_case(5'h0E, 8'hFF, 3'h0, 1'h1, 2'h2, 8'h00);
        skip_case(5'h0E, 8'h05, 3'h0, 1'h0, 2'h2, 8'h06);
        skip_case(5'h11, 8'h10, 3'h4, 1'h1, 2'h0, 8'h00);
        skip_case(5'h11, 8'hEF, 3'h4, 1'h0, 2'h0, 8'h00);
        skip_case(5'h11, 8'h80, 3'h7, 1'h1, 2'h0, 8'h00);
        skip_case(5'h12, 8'h00, 3'h0, 1'h0, 2'h1, 8'h00);
        skip_case(5'h12, 8'h40, 3'h0, 1'h1, 2'h1, 8'h40);
    endtask : t_skips

    task automatic t_dummy;
        @(posedge i_clk);
        drive(rss_pkg::OP_INC_SKIP_NIL, 8'h10, 1'h0, 1'h0, 3'h0, 8'h00);
        @(posedge i_clk);
        drive(rss_pkg::OP_FILL_ONES, 8'h10, 1'h0, 1'h0, 3'h0, 8'h00);
        #1;
        check(8'({done, ready}), 8'h02);
        @(posedge i_clk);
        #1;
        check(8'({done, ready}), 8'h01);
        @(posedge i_clk);
        req_valid <= 1'h0;
        load <= 1'h0;
        #1;
        check(8'({done, mem_we}), 8'h03);
        check(wdata, 8'hFF);
        check(8'(flags), 8'(exp_fl));
    endtask : t_dummy

    task automatic t_b2b;
        @(posedge i_clk);
        drive(rss_pkg::OP_NIBBLE_EXCHANGE, 8'hC3, 1'h0, 1'h0, 3'h0, 8'h00);
        @(posedge i_clk);
        drive(rss_pkg::OP_LOAD_WORK, 8'h00, 1'h1, 1'h0, 3'h0, 8'h96);
        #1;
        check(8'({done, mem_we}), 8'h03);
        check(wdata, 8'h3C);
        check(8'(flags), 8'(exp_fl));
        @(posedge i_clk);
        req_valid <= 1'h0;
        load <= 1'h0;
        #1;
        check(8'({done, mem_we}), 8'h02);
        check(work, 8'h96);
    endtask : t_b2b

    task automatic t_bits;
        for (int i = 0; i < 8; i++) begin
            issue(rss_pkg::OP_BIT_SET, 8'h5A, 1'h0, 1'h0, 3'(i), 8'h00);
            check(wdata, 8'h5A | (8'h01 << i));
            check(8'({mem_we, flags == exp_fl}), 8'h03);
        end
        issue(rss_pkg::op_t'(5'h1F), 8'h00, 1'h0, 1'h0, 3'h0, 8'h00);
        check(8'({done, mem_we, work == 8'h96}), 8'h01);
    endtask : t_bits

    initial begin
        i_rst_n = 1'h0;
        req_valid = 1'h0;
        req_op = rss_pkg::OP_NONE;
        req_imm_sel = 1'h0;
        req_to_mem = 1'h0;
        req_idx = 3'h0;
        req_imm = 8'h00;
        load = 1'h0;
        load_val = 8'h00;
        miscompares = 0;
        tests_run = 0;
        exp_skips = 0;
        exp_fl = 6'h00;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'h1;
        #1;
        check(8'({ready, done, skip, mem_we}), 8'h08);
        check(work, 8'h00);
        check(8'(flags), 8'h00);
        t_rotates();
        t_subtract();
        t_skips();
        t_dummy();
        t_b2b();
        t_bits();
        @(posedge i_clk);
        #1;
        check(skips, 8'(exp_skips));
        results();
    end

    initial begin
        repeat (2000) @(posedge i_clk);
        miscompares = miscompares + 1;
        results();
    end
endmodule : rotate_subtract_skip_alu_tb
